// ---- include/vco_tune_regs.svh ----
// Register offsets, field positions, reset values and timing counts for the oscillator tuning block.
// Assumes an 8-bit register address and 8-bit register data.
`ifndef VCO_TUNE_REGS_SVH
`define VCO_TUNE_REGS_SVH

`define OFS_OSC_TRIM 8'h59
`define OFS_SYNTH_RESET 8'h5c
`define OFS_OSC_TUNE_CONTROL 8'h5d
`define OFS_OSC_TUNE_STATUS 8'h5e
`define OFS_CONVERTER_TRIM_RUN 8'h61

`define SETTLE_SEL_MSB 6
`define SETTLE_SEL_LSB 4
`define TUNE_ENABLE_BIT 0
`define TUNE_DONE_BIT 0
`define CAL_RUN_BIT 0
`define SYNTH_RESET_BIT 0
`define TRIM_MSB 6

`define RST_SETTLE_SEL 3'h4
`define RST_TUNE_ENABLE 1'h0
`define RST_CAL_RUN 1'h1
`define RST_SYNTH_RESET 1'h0
`define RST_TRIM 7'h00
`define TRIM_MIDSCALE 7'h40

// One settle unit is 1000 ns; at 50 ns per cycle this is a least time, so it rounds up.
`define SETTLE_UNIT_NS 1000
`define CLK_PERIOD_NS 50
`define SETTLE_UNIT_CYC ((`SETTLE_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- include/vco_tune_pkg.sv ----
// Types shared by the tuning controller and its search engine.
// Assumes nothing beyond a SystemVerilog compiler.
package vco_tune_pkg;
  typedef logic [6:0] trim_t;
  typedef logic [2:0] settle_sel_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SETTLE = 3'b010,
    ST_DECIDE = 3'b100
  } tune_state_e;
endpackage

// ---- include/tune_if.sv ----
// Carries the start request, settle setting and trim updates between controller and search engine.
// Assumes both ends share one clock.
interface tune_if;
  import vco_tune_pkg::*;
  logic start;
  settle_sel_t settle_sel;
  logic busy;
  logic finish;
  logic code_we;
  trim_t code;
  modport ctrl (output start, output settle_sel, input busy, input finish, input code_we, input code);
  modport eng (input start, input settle_sel, output busy, output finish, output code_we, output code);
endinterface

// ---- logic/tune_engine.sv ----
// Successive-approximation search of the oscillator trim code.
// Assumes osc_fast is a synchronous frequency-comparator result, high when the oscillator runs above target.
`include "vco_tune_regs.svh"
module tune_engine
  import vco_tune_pkg::*;
#(
  parameter int UNIT_CYC = `SETTLE_UNIT_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic osc_fast,
  tune_if.eng tif
);
  tune_state_e state_r;
  logic [11:0] wait_r;
  logic [2:0] bit_r;
  trim_t code_r;
  logic finish_r;
  logic code_we_r;

  // Wait per trim step grows with the settle setting: (sel + 1) units.
  wire [11:0] settle_cyc = 12'((int'(tif.settle_sel) + 1) * UNIT_CYC); // R1
  wire trim_t keep_mask = ~(trim_t'(1) << bit_r);
  wire trim_t decided = osc_fast ? (code_r & keep_mask) : code_r; // R3
  wire trim_t next_try = (bit_r == 3'h0) ? decided : (decided | (trim_t'(1) << (bit_r - 3'h1)));

  assign tif.busy = (state_r != ST_IDLE);
  assign tif.finish = finish_r;
  assign tif.code_we = code_we_r;
  assign tif.code = code_r;

  // Each step holds a trial code for the settle time, then keeps or drops the tested bit.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      wait_r <= 12'h000;
      bit_r <= 3'h0;
      code_r <= `RST_TRIM;
      finish_r <= 1'b0;
      code_we_r <= 1'b0;
    end else if (ce) begin
      finish_r <= 1'b0;
      code_we_r <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          if (tif.start) begin
            code_r <= `TRIM_MIDSCALE; // R3
            code_we_r <= 1'b1;
            bit_r <= 3'(`TRIM_MSB);
            wait_r <= settle_cyc; // R1
            state_r <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          wait_r <= wait_r - 12'h001;
          if (wait_r <= 12'h001) begin
            state_r <= ST_DECIDE;
          end
        end
        ST_DECIDE: begin
          code_r <= next_try; // R3
          code_we_r <= 1'b1;
          if (bit_r == 3'h0) begin
            finish_r <= 1'b1;
            state_r <= ST_IDLE;
          end else begin
            bit_r <= bit_r - 3'h1;
            wait_r <= settle_cyc;
            state_r <= ST_SETTLE;
          end
        end
      endcase
    end
  end
endmodule

// ---- logic/vco_tune_and_cal_enable_ctrl.sv ----
// Register file and sequencing for oscillator tuning and the converter calibration enable.
// Assumes a synchronous byte-wide register port fed by the serial control port decoder.
// Assumes ce low freezes every register here, the search engine included.
`include "vco_tune_regs.svh"

// How it works
// R1: Bits 6:4 pick the settle wait after each trim change; reset value 4.
// R2: Bit 0 enables tuning; tuning starts when synth reset is written to zero.
// R3: The engine searches the trim code to centre the oscillator frequency.
// R4: Software changes tuning control only while synth reset is one.
// R5: Done reads one after tuning finishes, or when tuning was skipped.
// R6: Software leaves the trim code alone until done reads one.
// R7: Calibration enable, reset one, runs calibration; zero holds it in reset.
// R8: Clearing calibration enable resets the digital and serial link dividers.
// R9: Software clears calibration enable around marked calibration register changes.
// R10: Calibration enable goes up before link enable and down after it.
// R11: Reserved control bits are written as zero.
// R12: Synth reset is set before synthesizer programming and cleared after.
// R13: Seven-bit trim code is set by the engine and readable and writable.
// R14: Done reads zero from tuning start until completion; a start in the finish cycle leaves it one, and a skip during a search sets it.
module vco_tune_and_cal_enable_ctrl
  import vco_tune_pkg::*;
#(
  parameter int UNIT_CYC = `SETTLE_UNIT_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  input wire logic osc_fast,
  input wire logic serial_link_enable,
  output logic [6:0] osc_trim_code,
  output logic synth_reset,
  output logic tune_busy,
  output logic cal_run,
  output logic div_reset_n,
  output logic link_div_reset_n,
  output logic order_fault
);
  // Handshake with the search engine; start is a one-cycle strobe and finish a one-cycle pulse.
  tune_if tif ();

  // Software-visible fields and the flops behind every output.
  settle_sel_t settle_sel_r;
  logic tune_engine_enable_r;
  logic tune_done_r;
  logic cal_run_r;
  logic synth_reset_r;
  trim_t trim_r;
  logic [7:0] rdata_r;
  logic busy_r;
  logic order_fault_r;

  // Address decode of the register port.
  // Only the five mapped offsets decode; anything else reads zero and writes nothing.
  wire sel_trim = (reg_addr == `OFS_OSC_TRIM);
  wire sel_rst = (reg_addr == `OFS_SYNTH_RESET);
  wire sel_ctl = (reg_addr == `OFS_OSC_TUNE_CONTROL);
  wire sel_sts = (reg_addr == `OFS_OSC_TUNE_STATUS);
  wire sel_cal = (reg_addr == `OFS_CONVERTER_TRIM_RUN);

  // Write strobes per register; ce gates them at the flops, not here.
  wire wr_trim = reg_we && sel_trim;
  wire wr_rst = reg_we && sel_rst;
  wire wr_ctl = reg_we && sel_ctl;
  wire wr_cal = reg_we && sel_cal;

  // A start needs a one-to-zero write of synth reset; a repeat zero write does not retrigger.
  // Enable is looked at on that write, so software must set it while synth reset is still high.
  // A release during a running search does not restart it, which keeps the
  // trim code from jumping back to midscale under a live loop.
  wire release_wr = wr_rst && synth_reset_r && !reg_wdata[`SYNTH_RESET_BIT]; // R2 R12
  wire start_tune = release_wr && tune_engine_enable_r && !tif.busy; // R2
  wire skip_tune = release_wr && !tune_engine_enable_r; // R5

  // Engine request and its settle setting.
  assign tif.start = start_tune;
  assign tif.settle_sel = settle_sel_r; // R1

  // Read words; reserved bits read zero.
  wire [7:0] rd_trim = {1'b0, trim_r}; // R13
  wire [7:0] rd_rst = {7'h00, synth_reset_r};
  wire [7:0] rd_ctl = {1'b0, settle_sel_r, 3'h0, tune_engine_enable_r};
  wire [7:0] rd_sts = {7'h00, tune_done_r}; // R5
  wire [7:0] rd_cal = {7'h00, cal_run_r}; // R7

  // Read mux; unmapped addresses read zero, so a wrong address never looks like a live register.
  wire [7:0] rd_mux = sel_trim ? rd_trim :
                      sel_rst ? rd_rst :
                      sel_ctl ? rd_ctl :
                      sel_sts ? rd_sts :
                      sel_cal ? rd_cal :
                      8'h00;

  // Tuning control holds only the defined fields, so reserved writes are dropped.
  // Reserved bits therefore read back as zero whatever was written.
  // Writes while synth reset is low are still taken; keeping to that window is software's duty.
  wire settle_sel_t settle_sel_nxt = reg_wdata[`SETTLE_SEL_MSB:`SETTLE_SEL_LSB]; // R1
  wire tune_enable_nxt = reg_wdata[`TUNE_ENABLE_BIT]; // R2
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_sel_r <= `RST_SETTLE_SEL;
      tune_engine_enable_r <= `RST_TUNE_ENABLE;
    end else if (ce && wr_ctl) begin
      settle_sel_r <= settle_sel_nxt; // R1
      tune_engine_enable_r <= tune_enable_nxt; // R2
    end
  end

  // Synth reset bit; it leaves reset low, so no search starts before software has armed it.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      synth_reset_r <= `RST_SYNTH_RESET;
    end else if (ce && wr_rst) begin
      synth_reset_r <= reg_wdata[`SYNTH_RESET_BIT]; // R12
    end
  end

  // Calibration enable bit; it leaves reset high, so calibration and the dividers run by default.
  // Clearing it also holds both divider resets low through the output copies below.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_run_r <= `RST_CAL_RUN;
    end else if (ce && wr_cal) begin
      cal_run_r <= reg_wdata[`CAL_RUN_BIT]; // R7
    end
  end

  // Engine updates win over a software write, so a stray write cannot corrupt a running search.
  // A write while busy is dropped, not queued: replaying it after the search would undo the result.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_r <= `RST_TRIM;
    end else if (ce) begin
      if (tif.code_we) begin
        trim_r <= tif.code; // R13 R3
      end else if (wr_trim && !tif.busy) begin
        trim_r <= reg_wdata[6:0]; // R13 R6
      end
    end
  end

  // Done is cleared by a start and set by the finish or a skip; a finish and a start can coincide, and then the set wins.
  // It is low out of reset: no search has run yet, and even a skip needs a release first.
  wire done_set = tif.finish || skip_tune; // R5
  wire done_clr = start_tune; // R14
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tune_done_r <= 1'b0;
    end else if (ce) begin
      if (done_set) begin
        tune_done_r <= 1'b1; // R5
      end else if (done_clr) begin
        tune_done_r <= 1'b0; // R14
      end
    end
  end

  // Registered read data; it holds until the next read.
  // Reads have no side effects, so polling the status cannot disturb a search.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (ce && reg_re) begin
      rdata_r <= rd_mux;
    end
  end

  // Busy copy for the pin; it rises on the start edge itself, so it never lags the start.
  // It falls one cycle after the engine returns to idle, on the edge at which done rises.
  wire busy_nxt = tif.busy || start_tune;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
    end else if (ce) begin
      busy_r <= busy_nxt;
    end
  end

  // Sticky ordering monitor: link enable high while calibration is held off.
  // Only reset clears it, so a brief violation between polls is still seen.
  // It only reports; holding the link off is left to the logic that owns the link enable.
  wire order_bad = serial_link_enable && !cal_run_r; // R10
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      order_fault_r <= 1'b0;
    end else if (ce && order_bad) begin
      order_fault_r <= 1'b1; // R10
    end
  end

  // Search engine; the settle unit is a parameter so that simulation can shorten the waits.
  tune_engine #(
    .UNIT_CYC(UNIT_CYC)
  ) u_engine (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .osc_fast(osc_fast),
    .tif(tif)
  );

  // Output copies; each one is a flop of this module.
  assign reg_rdata = rdata_r;
  assign osc_trim_code = trim_r;
  assign synth_reset = synth_reset_r;
  assign tune_busy = busy_r;
  assign cal_run = cal_run_r; // R7
  // Both divider resets share the calibration enable flop, so they release on the same edge.
  // A separate flop per divider could skew the two releases by a cycle.
  assign div_reset_n = cal_run_r; // R8
  assign link_div_reset_n = cal_run_r; // R8
  assign order_fault = order_fault_r;
endmodule

// ---- tb/vco_tune_and_cal_enable_ctrl_sva.sv ----
// Assertions on the tuning and calibration enable block.
// Sees only the top ports; the bind at the foot attaches it.
module vco_tune_and_cal_enable_ctrl_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [7:0] reg_rdata,
  input wire logic osc_fast,
  input wire logic serial_link_enable,
  input wire logic [6:0] osc_trim_code,
  input wire logic synth_reset,
  input wire logic tune_busy,
  input wire logic cal_run,
  input wire logic div_reset_n,
  input wire logic link_div_reset_n,
  input wire logic order_fault
);
  logic start_r;
  logic [11:0] busy_cyc_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Remembers a legal start request, since busy may only rise because of one.
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) start_r <= 1'h0;
    else start_r <= ce && reg_we && reg_addr == 8'h5c && !reg_wdata[0] && synth_reset;
  // Length of the running search; the slowest setting at the default unit needs about 1130 cycles.
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) busy_cyc_r <= 12'h000;
    else busy_cyc_r <= tune_busy ? busy_cyc_r + 12'h001 : 12'h000;
  chk_start_cause: assert property ($rose(tune_busy) |-> start_r) else $error("busy without start");
  chk_start_mid: assert property ($rose(tune_busy) |=> osc_trim_code == 7'h40) else $error("bad first code");
  chk_busy_ends: assert property (tune_busy |-> busy_cyc_r < 12'h500) else $error("tuning hangs");
  chk_synth_wr: assert property (ce && reg_we && reg_addr == 8'h5c |=> synth_reset == $past(reg_wdata[0]))
    else $error("synth reset not written");
  chk_cal_wr: assert property (ce && reg_we && reg_addr == 8'h61 |=> cal_run == $past(reg_wdata[0]))
    else $error("cal run not written");
  chk_div_follow: assert property (!cal_run |-> ##[0:1] !div_reset_n && !link_div_reset_n)
    else $error("dividers not reset");
  chk_order_set: assert property (ce && serial_link_enable && !cal_run |-> ##[1:2] order_fault)
    else $error("order fault missed");
  chk_order_keep: assert property (order_fault |=> order_fault) else $error("order fault cleared");
endmodule
bind vco_tune_and_cal_enable_ctrl vco_tune_and_cal_enable_ctrl_sva chk (.*);

// ---- tb/vco_tune_and_cal_enable_ctrl_tb.sv ----
// Bench for the tuning and calibration enable block, checked against a register model.
// Drives the register port itself; a comparator stand-in chases a random target code.
module vco_tune_and_cal_enable_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int U = 2;
  logic core_clk = 1'h0, rst_n = 1'h0, ce = 1'h1, reg_we = 1'h0, reg_re = 1'h0, osc_fast = 1'h0;
  logic serial_link_enable = 1'h0, synth_reset, tune_busy, cal_run, div_reset_n, link_div_reset_n, order_fault;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [6:0] osc_trim_code;
  logic [7:0] q[$] = '{8'h59, 8'h5c, 8'h5d, 8'h5e, 8'h60, 8'h61};
  int num_errors = 0, checks = 0, cyc = 0, target = 0, mbusy = 0, n0, n7, m[256];
  vco_tune_and_cal_enable_ctrl #(.UNIT_CYC(U)) dut (.*);
  // Core clock, 50 ns period.
  initial forever #25 core_clk = ~core_clk;
  // Comparator stand-in and watchdog; a hang counts as a mismatch.
  always @(posedge core_clk) begin
    osc_fast <= osc_trim_code > target;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  // The model follows each write taken with ce high, so refused trim writes during a search leave it alone.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_we <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_we <= 1'h0;
    if (ce && a == 8'h5c && !d[0] && m[8'h5c]) begin
      mbusy = m[8'h5d] & 1;
      m[8'h5e] = !mbusy;
    end
    if (ce && (a inside {8'h5c, 8'h5d, 8'h61} || a == 8'h59 && !mbusy))
      m[a] = d & (a == 8'h59 ? 8'h7f : a == 8'h5d ? 8'h71 : 8'h01);
  endtask
  task automatic rc(input logic [7:0] a);
    @(posedge core_clk);
    reg_re <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_re <= 1'h0;
    #1 chk(reg_rdata, m[a][7:0]);
  endtask
  // One full search; the model finds the code by the same bit-by-bit trial.
  task automatic tune(input int sel, output int n);
    int c = 0;
    target = $urandom_range(127);
    wr(8'h5c, 8'h01);
    wr(8'h5d, 8'(sel << 4 | 1));
    wr(8'h5c, 8'h00);
    rc(8'h5e);
    wr(8'h59, 8'h2a);
    #1;
    for (n = 0; tune_busy === 1'h1 && n < 1000; n++) begin
      @(posedge core_clk);
      #1;
    end
    for (int b = 6; b >= 0; b--) begin
      c = c | 1 << b;
      if (c > target) c = c & ~(1 << b);
    end
    mbusy = 0;
    m[8'h5e] = 1;
    m[8'h59] = c;
    rc(8'h5e);
    rc(8'h59);
    chk(osc_trim_code, 8'(c));
    $display("tune test done");
  endtask
  task automatic conclude();
    $display("errors %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Main sequence: reset values, reserved bits, skipped and full searches, trim access, enable order.
  initial begin
    m[8'h5d] = 8'h40;
    m[8'h61] = 1;
    void'($urandom(32'h4a7f));
    repeat (6) @(posedge core_clk);
    rst_n <= 1'h1;
    foreach (q[i]) rc(q[i]);
    $display("reset test done");
    wr(8'h5c, 8'h01);
    wr(8'h5d, 8'hff);
    wr(8'h5e, 8'hff);
    wr(8'h60, 8'hff);
    wr(8'h61, 8'hfe);
    @(posedge core_clk);
    #1 chk({cal_run, div_reset_n, link_div_reset_n}, 8'h00);
    chk(synth_reset, 8'h01);
    foreach (q[i]) rc(q[i]);
    wr(8'h61, 8'h01);
    @(posedge core_clk);
    #1 chk({cal_run, div_reset_n, link_div_reset_n}, 8'h07);
    $display("reserved test done");
    ce <= 1'h0;
    wr(8'h5d, 8'h50);
    ce <= 1'h1;
    rc(8'h5d);
    $display("clock enable test done");
    wr(8'h5d, 8'h30);
    wr(8'h5c, 8'h00);
    rc(8'h5e);
    $display("skip test done");
    tune(0, n0);
    tune(7, n7);
    chk(8'(n7 - n0), 8'(49 * U));
    wr(8'h59, 8'($urandom_range(255)));
    rc(8'h59);
    @(posedge core_clk);
    serial_link_enable <= 1'h1;
    repeat (3) @(posedge core_clk);
    serial_link_enable <= 1'h0;
    wr(8'h61, 8'h00);
    #1 chk(order_fault, 8'h00);
    @(posedge core_clk);
    serial_link_enable <= 1'h1;
    repeat (3) @(posedge core_clk);
    #1 chk(order_fault, 8'h01);
    $display("order test done");
    conclude();
  end
endmodule
